// ### sqc_cond_eval.sv
`timescale 1ns/1ps
module sqc_cond_eval
(
   input sqc_pkg::sqc_cond_t code,
   input wire logic [7:0] flags,
   input wire logic ceExpired,
   output logic result
);
   import sqc_pkg::*;

   logic lessEq;
   logic lessThan;

   always_comb
   begin
      lessThan = flags[FL_NEG] ^ flags[FL_OVF];
      lessEq = lessThan | flags[FL_ZERO];
      case (code)
         C_EQ: result = flags[FL_ZERO];
         C_NE: result = !flags[FL_ZERO];
         C_LT: result = lessThan;
         C_GE: result = !lessThan;
         C_LE: result = lessEq;
         C_GT: result = !lessEq;
         C_AC: result = flags[FL_CARRY];
         C_NAC: result = !flags[FL_CARRY];
         C_AV: result = flags[FL_OVF];
         C_NAV: result = !flags[FL_OVF];
         C_MV: result = flags[FL_MOVF];
         C_NMV: result = !flags[FL_MOVF];
         C_NEG: result = flags[FL_XSIGN];
         C_POS: result = !flags[FL_XSIGN];
         C_NCE: result = !ceExpired;
         default: result = 1'b1;
      endcase
   end
endmodule

// ### sqc_pkg.sv
package sqc_pkg;

   // arithmetic flag positions
   localparam int FL_ZERO = 0;
   localparam int FL_NEG = 1;
   localparam int FL_OVF = 2;
   localparam int FL_CARRY = 3;
   localparam int FL_XSIGN = 4;
   localparam int FL_QUOT = 5;
   localparam int FL_MOVF = 6;
   localparam int FL_SSIGN = 7;

   // mode control positions
   localparam int MD_BANK = 0;
   localparam int MD_REV = 1;
   localparam int MD_OVLATCH = 2;
   localparam int MD_SAT = 3;
   localparam int MD_FRAC = 4;
   localparam int MD_TIMER = 5;
   localparam int MD_GO = 6;

   localparam logic [6:0] MODE_RESET = 7'h00;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [15:0] SAT_POS = 16'h7FFF;
   localparam logic [15:0] SAT_NEG = 16'h8000;

   // register port offsets
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_FLAGS = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_PCTOP = 8'h0C;

   // register ids used by moves, and stack depths
   localparam int NDATA = 19;
   localparam int NDAG = 24;
   localparam logic [5:0] ID_AR = 6'h05;
   localparam logic [5:0] ID_DAG_BASE = 6'h20;
   localparam int PCD = 16;
   localparam int SSD = 4;

   typedef enum logic [3:0] {
      C_EQ = 4'h0, C_NE = 4'h1, C_LT = 4'h2, C_GE = 4'h3,
      C_LE = 4'h4, C_GT = 4'h5, C_AC = 4'h6, C_NAC = 4'h7,
      C_AV = 4'h8, C_NAV = 4'h9, C_MV = 4'hA, C_NMV = 4'hB,
      C_NEG = 4'hC, C_POS = 4'hD, C_NCE = 4'hE, C_TRUE = 4'hF
   } sqc_cond_t;

   typedef enum logic [3:0] {
      OP_NOP = 4'h0, OP_MODE_SET = 4'h1, OP_MODE_CLR = 4'h2,
      OP_REG_WRITE = 4'h3, OP_TOS_READ = 4'h4, OP_TOS_WRITE = 4'h5,
      OP_PC_POP = 4'h6, OP_CALL = 4'h7, OP_JUMP = 4'h8, OP_RTS = 4'h9,
      OP_RTI = 4'hA, OP_INT_ENTRY = 4'hB, OP_ARITH = 4'hC
   } sqc_op_t;

   typedef struct packed {
      logic valid;
      sqc_op_t op;
      sqc_cond_t cond;
      logic useFlagIn;
      logic flagInHigh;
      logic [6:0] modeMask;
      logic [5:0] regId;
      logic [15:0] data;
      logic [13:0] target;
      logic [9:0] imask;
   } sqc_instr_t;

   typedef struct packed {
      logic aluValid;
      logic [15:0] aluResult;
      logic aluZero;
      logic aluNeg;
      logic aluOvf;
      logic aluCarry;
      logic absValid;
      logic xSign;
      logic macValid;
      logic macOvf;
   } sqc_arith_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } sqc_bus_t;

endpackage

// ### sqc_sequencer.sv
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - mode register takes full writes plus per-bit set and clear commands.
// - reversed mode bit-reverses every first-generator address.
// - bank bit zero picks primary data registers, one picks secondary.
// - secondary bank duplicates every alu, mac and shifter register.
// - latch mode keeps overflow set until software writes zero.
// - saturation forces result to 7FFF or 8000 on overflow.
// - result placement bit selects integer or fractional multiplier format.
// - timer bit set runs the down timer, cleared stops it.
// - go mode runs on during grant, stalls only for external access.
// - without go mode, execution stalls throughout any bus grant.
// - sixteen conditions from flags and counter gate conditional instructions.
// - loop termination condition on loop stack decides loop continuation.
// - less-or-equal is (neg xor ovf) or zero; greater-than its inverse.
// - carry, overflow, mult overflow conditions test flag one or zero.
// - negative-input tests x sign one, positive-input tests it zero.
// - flag-pin conditions use last sample, only on jump and call.
// - pop discards; top read copies entry and pops one cycle later.
// - top write pushes the source value in the same cycle.
// - top moves accept only data and address-generator registers.
// - interrupt entry saves flags, mode and mask; return restores them.
module sqc_sequencer
(
   input wire logic clk,
   input wire logic rst_n,
   input sqc_pkg::sqc_bus_t bus,
   output logic [15:0] rdata,
   input sqc_pkg::sqc_instr_t instr,
   input sqc_pkg::sqc_arith_t arith,
   input wire logic [13:0] dagAddr,
   output logic [13:0] dagAddrOut,
   input wire logic busGrant,
   input wire logic extAccess,
   output logic stall,
   input wire logic flagInPin,
   input wire logic ceExpired,
   input wire logic loopEnd,
   input sqc_pkg::sqc_cond_t loopCond,
   output logic loopContinue,
   output logic execTaken,
   output logic branchTaken,
   output logic [13:0] branchTarget,
   output logic [9:0] imaskRestore,
   output logic imaskRestoreValid,
   output logic bankSel,
   output logic fracMode,
   output logic timerRun
);
   import sqc_pkg::*;

   typedef struct packed {
      logic [6:0] mode;
      logic [7:0] flags;
      logic flagSample;
      logic [1:0][NDATA-1:0][15:0] bank;
      logic [NDAG-1:0][13:0] dag;
      logic [PCD-1:0][13:0] pcStk;
      logic [4:0] pcDepth;
      logic popPending;
      logic [SSD-1:0][24:0] stStk;
      logic [2:0] stDepth;
      logic illegal;
      logic [15:0] rdata;
      logic [13:0] dagAddrOut;
      logic stall;
      logic loopContinue;
      logic execTaken;
      logic branchTaken;
      logic [13:0] branchTarget;
      logic [9:0] imaskRestore;
      logic imaskRestoreValid;
   } sqc_state_t;

   sqc_state_t st;
   sqc_state_t next_st;
   logic condOk;
   logic loopDone;
   logic [13:0] revAddr;
   logic [15:0] srcVal;
   logic srcLegal;
   logic [13:0] pcTop;
   logic [4:0] pcIdx;
   logic [4:0] depthAfterPop;

   sqc_cond_eval u_cond
   (
      .code(instr.cond),
      .flags(st.flags),
      .ceExpired(ceExpired),
      .result(condOk)
   );

   sqc_cond_eval u_loop_cond
   (
      .code(loopCond),
      .flags(st.flags),
      .ceExpired(ceExpired),
      .result(loopDone)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 14; gi++)
      begin : g_rev
         assign revAddr[gi] = dagAddr[13 - gi];
      end
   endgenerate

   assign pcIdx = (st.pcDepth == 5'h00) ? 5'h00 : st.pcDepth - 5'h01;
   assign pcTop = st.pcStk[pcIdx[3:0]];

   // legal source/destination and its value in the active bank
   always_comb
   begin
      srcLegal = 1'b0;
      srcVal = 16'h0000;
      if (instr.regId < 6'(NDATA))
      begin
         srcLegal = 1'b1;
         srcVal = st.bank[st.mode[MD_BANK]][instr.regId[4:0]];
      end
      else if (instr.regId >= ID_DAG_BASE &&
               instr.regId < ID_DAG_BASE + 6'(NDAG))
      begin
         srcLegal = 1'b1;
         srcVal = {2'b00, st.dag[5'(instr.regId - ID_DAG_BASE)]};
      end
   end

   always_comb
   begin
      logic active;
      logic exec;
      logic flagCond;
      logic doPop;
      logic [4:0] wrIdx;
      logic [15:0] aluVal;
      active = 1'b0;
      exec = 1'b0;
      flagCond = 1'b0;
      doPop = 1'b0;
      wrIdx = 5'h00;
      aluVal = 16'h0000;
      next_st = st;
      next_st.flagSample = flagInPin;
      next_st.branchTaken = 1'b0;
      next_st.imaskRestoreValid = 1'b0;
      next_st.execTaken = 1'b0;
      next_st.loopContinue = 1'b0;
      depthAfterPop = st.pcDepth;

      // bus writes first so that instruction and hardware events win
      if (bus.wr)
      begin
         case (bus.addr)
            OFF_MODE: next_st.mode = bus.wdata[6:0];
            OFF_FLAGS: next_st.flags = bus.wdata[7:0];
            OFF_STATUS:
               if (bus.wdata[0])
                  next_st.illegal = 1'b0;
            default: next_st.illegal = next_st.illegal;
         endcase
      end

      // delayed pop left over from a top read
      if (st.popPending && st.pcDepth != 5'h00)
      begin
         depthAfterPop = st.pcDepth - 5'h01;
      end
      next_st.popPending = 1'b0;
      next_st.pcDepth = depthAfterPop;

      active = instr.valid && !st.stall;
      if (instr.useFlagIn)
      begin
         flagCond = instr.flagInHigh ? st.flagSample : !st.flagSample;
         exec = (instr.op == OP_JUMP || instr.op == OP_CALL) &&
                flagCond;
      end
      else
      begin
         exec = condOk;
      end
      exec = exec && active;
      next_st.execTaken = exec;

      if (exec)
      begin
         case (instr.op)
            OP_MODE_SET: next_st.mode = next_st.mode | instr.modeMask;
            OP_MODE_CLR: next_st.mode = next_st.mode & ~instr.modeMask;
            OP_REG_WRITE:
               if (instr.regId < 6'(NDATA))
                  next_st.bank[st.mode[MD_BANK]][instr.regId[4:0]] =
                     instr.data;
               else if (srcLegal)
                  next_st.dag[5'(instr.regId - ID_DAG_BASE)] =
                     instr.data[13:0];
            OP_TOS_READ:
               if (!srcLegal)
                  next_st.illegal = 1'b1;
               else
               begin
                  if (instr.regId < 6'(NDATA))
                     next_st.bank[st.mode[MD_BANK]][instr.regId[4:0]] =
                        {2'b00, pcTop};
                  else
                     next_st.dag[5'(instr.regId - ID_DAG_BASE)] = pcTop;
                  next_st.popPending = 1'b1;
               end
            OP_TOS_WRITE:
               if (!srcLegal)
                  next_st.illegal = 1'b1;
               else if (depthAfterPop < 5'(PCD))
               begin
                  next_st.pcStk[depthAfterPop[3:0]] = srcVal[13:0];
                  next_st.pcDepth = depthAfterPop + 5'h01;
               end
            OP_PC_POP: doPop = 1'b1;
            OP_CALL:
            begin
               if (depthAfterPop < 5'(PCD))
               begin
                  next_st.pcStk[depthAfterPop[3:0]] = instr.data[13:0];
                  next_st.pcDepth = depthAfterPop + 5'h01;
               end
               next_st.branchTaken = 1'b1;
               next_st.branchTarget = instr.target;
            end
            OP_JUMP:
            begin
               next_st.branchTaken = 1'b1;
               next_st.branchTarget = instr.target;
            end
            OP_RTS:
            begin
               doPop = 1'b1;
               next_st.branchTaken = 1'b1;
               next_st.branchTarget = st.pcStk[4'(depthAfterPop - 5'h01)];
            end
            OP_RTI:
            begin
               doPop = 1'b1;
               next_st.branchTaken = 1'b1;
               next_st.branchTarget = st.pcStk[4'(depthAfterPop - 5'h01)];
               if (st.stDepth != 3'h0)
               begin
                  wrIdx = 5'(st.stDepth - 3'h1);
                  {next_st.flags, next_st.mode, next_st.imaskRestore} =
                     st.stStk[wrIdx[1:0]];
                  next_st.imaskRestoreValid = 1'b1;
                  next_st.stDepth = st.stDepth - 3'h1;
               end
            end
            OP_INT_ENTRY:
            begin
               if (depthAfterPop < 5'(PCD))
               begin
                  next_st.pcStk[depthAfterPop[3:0]] = instr.data[13:0];
                  next_st.pcDepth = depthAfterPop + 5'h01;
               end
               if (st.stDepth < 3'(SSD))
               begin
                  next_st.stStk[st.stDepth[1:0]] =
                     {st.flags, st.mode, instr.imask};
                  next_st.stDepth = st.stDepth + 3'h1;
               end
               next_st.branchTaken = 1'b1;
               next_st.branchTarget = instr.target;
            end
            default: next_st.popPending = next_st.popPending;
         endcase
      end

      // pop without keeping the value
      if (doPop && depthAfterPop != 5'h00)
      begin
         next_st.pcDepth = depthAfterPop - 5'h01;
      end

      // arithmetic status; set beats a software clear in the same cycle
      if (arith.aluValid)
      begin
         next_st.flags[FL_ZERO] = arith.aluZero;
         next_st.flags[FL_NEG] = arith.aluNeg;
         next_st.flags[FL_CARRY] = arith.aluCarry;
         if (st.mode[MD_OVLATCH])
            next_st.flags[FL_OVF] = next_st.flags[FL_OVF] |
                                    arith.aluOvf;
         else
            next_st.flags[FL_OVF] = arith.aluOvf;
         aluVal = arith.aluResult;
         if (st.mode[MD_SAT] && arith.aluOvf)
            aluVal = arith.aluResult[15] ? SAT_POS : SAT_NEG;
         next_st.bank[st.mode[MD_BANK]][ID_AR[4:0]] = aluVal;
      end
      if (arith.absValid)
         next_st.flags[FL_XSIGN] = arith.xSign;
      if (arith.macValid)
         next_st.flags[FL_MOVF] = arith.macOvf;

      // grant handling
      next_st.stall = busGrant &&
                      (!next_st.mode[MD_GO] || extAccess);

      if (loopEnd)
         next_st.loopContinue = !loopDone;

      next_st.dagAddrOut = st.mode[MD_REV] ? revAddr : dagAddr;

      next_st.rdata = 16'h0000;
      if (bus.rd)
      begin
         case (bus.addr)
            OFF_MODE: next_st.rdata = {9'h000, st.mode};
            OFF_FLAGS: next_st.rdata = {8'h00, st.flags};
            OFF_STATUS: next_st.rdata = {8'h00, st.stDepth,
                                         st.pcDepth[3:0], st.illegal};
            OFF_PCTOP: next_st.rdata = {2'b00, pcTop};
            default: next_st.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st <= '0;
         st.mode <= MODE_RESET;
         st.flags <= FLAGS_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign dagAddrOut = st.dagAddrOut;
   assign stall = st.stall;
   assign loopContinue = st.loopContinue;
   assign execTaken = st.execTaken;
   assign branchTaken = st.branchTaken;
   assign branchTarget = st.branchTarget;
   assign imaskRestore = st.imaskRestore;
   assign imaskRestoreValid = st.imaskRestoreValid;
   assign bankSel = st.mode[MD_BANK];
   assign fracMode = st.mode[MD_FRAC];
   assign timerRun = st.mode[MD_TIMER];
endmodule

// ### sqc_sequencer_monitor.sv
`timescale 1ns/1ps
module sqc_sequencer_monitor
(
   input wire logic clk,
   input wire logic rst_n,
   input sqc_pkg::sqc_bus_t bus,
   input sqc_pkg::sqc_instr_t instr,
   input wire logic [13:0] dagAddr,
   input wire logic [13:0] dagAddrOut,
   input wire logic busGrant,
   input wire logic extAccess,
   input wire logic stall,
   input wire logic ceExpired,
   input wire logic loopEnd,
   input sqc_pkg::sqc_cond_t loopCond,
   input wire logic loopContinue,
   input wire logic execTaken,
   input wire logic branchTaken,
   input wire logic [13:0] branchTarget,
   input wire logic bankSel,
   input wire logic fracMode,
   input wire logic timerRun
);
   import sqc_pkg::*;
   logic revMode;
   logic goMode;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   function automatic logic [13:0] rev14(input logic [13:0] a);
      logic [13:0] r;
      for (int k = 0; k < 14; k++)
      begin
         r[k] = a[13 - k];
      end
      return r;
   endfunction

   // shadow of mode bits that only the register bus changes in this bench
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         revMode <= 1'b0;
         goMode <= 1'b0;
      end
      else if (bus.wr && bus.addr == OFF_MODE)
      begin
         revMode <= bus.wdata[MD_REV];
         goMode <= bus.wdata[MD_GO];
      end
   end

   sequence modeWrite;
      bus.wr && bus.addr == OFF_MODE && !instr.valid;
   endsequence

   sequence plainIssue;
      instr.valid && !stall && !instr.useFlagIn && instr.cond == C_TRUE;
   endsequence

   mode_write_a: assert property (modeWrite |=> bankSel ==
      $past(bus.wdata[MD_BANK]) && fracMode == $past(bus.wdata[MD_FRAC])
      && timerRun == $past(bus.wdata[MD_TIMER])) else $error("mode write");
   timer_set_a: assert property (plainIssue ##0 (instr.op == OP_MODE_SET
      && instr.modeMask[MD_TIMER] && !bus.wr) |=> timerRun)
      else $error("timer set");
   timer_clr_a: assert property (plainIssue ##0 (instr.op == OP_MODE_CLR
      && instr.modeMask[MD_TIMER] && !bus.wr) |=> !timerRun)
      else $error("timer clear");
   addr_rev_a: assert property (!bus.wr |=> dagAddrOut ==
      ($past(revMode) ? rev14($past(dagAddr)) : $past(dagAddr)))
      else $error("address order");
   halt_grant_a: assert property (busGrant && !goMode && !bus.wr
      |=> stall) else $error("no halt on grant");
   go_run_a: assert property (busGrant && goMode && !extAccess
      && !bus.wr |=> !stall) else $error("go mode halted");
   go_ext_a: assert property (busGrant && goMode && extAccess
      && !bus.wr |=> stall) else $error("go mode external");
   exec_true_a: assert property (plainIssue ##0 instr.op == OP_ARITH
      |=> execTaken) else $error("exec missing");
   pin_refuse_a: assert property (instr.valid && !stall
      && instr.useFlagIn && instr.op != OP_JUMP && instr.op != OP_CALL
      |=> !execTaken) else $error("pin cond accepted");
   jump_target_a: assert property (plainIssue ##0 instr.op == OP_JUMP
      |=> branchTaken && branchTarget == $past(instr.target))
      else $error("jump target");
   loop_end_a: assert property (loopEnd && loopCond == C_TRUE
      |=> !loopContinue) else $error("loop continued");
   loop_nce_a: assert property (loopEnd && loopCond == C_NCE
      && ceExpired |=> loopContinue) else $error("loop ended");
endmodule

// ### sqc_sequencer_test.sv
`timescale 1ns/1ps
module sqc_sequencer_test;
   import sqc_pkg::*;
   typedef struct packed {
      sqc_cond_t cond;
      logic [7:0] flags;
      logic ce;
      logic exp;
   } sqc_row_t;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   sqc_bus_t bus = '0;
   sqc_instr_t instr = '0;
   sqc_arith_t arith = '0;
   logic [13:0] dagAddr = 14'h0000;
   logic busGrant = 1'h0;
   logic extAccess = 1'h0;
   logic flagInPin = 1'h0;
   logic ceExpired = 1'h0;
   logic loopEnd = 1'h0;
   sqc_cond_t loopCond = C_TRUE;
   logic [15:0] rdata;
   logic [13:0] dagAddrOut;
   logic [13:0] branchTarget;
   logic stall, loopContinue, execTaken, branchTaken;
   logic bankSel, fracMode, timerRun;
   logic [9:0] imaskRestore;
   logic imaskRestoreValid;
   logic [15:0] v;
   int miscompares = 0;
   int nChecks = 0;
   sqc_row_t rows [18];

   sqc_sequencer DUT (.clk, .rst_n, .bus, .rdata, .instr, .arith, .dagAddr,
      .dagAddrOut, .busGrant, .extAccess, .stall, .flagInPin, .ceExpired,
      .loopEnd, .loopCond, .loopContinue, .execTaken, .branchTaken,
      .branchTarget, .imaskRestore, .imaskRestoreValid, .bankSel,
      .fracMode, .timerRun);

   always #20 clk = ~clk;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      nChecks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic busWrite(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      bus <= {a, d, 1'h1, 1'h0};
      @(posedge clk);
      bus.wr <= 1'h0;
   endtask

   task automatic busRead(input logic [7:0] a);
      @(posedge clk);
      bus <= {a, 16'h0000, 1'h0, 1'h1};
      @(posedge clk);
      bus.rd <= 1'h0;
      #1 v = rdata;
   endtask

   // result of the instruction is sampled just after the edge that takes it
   task automatic issue(input sqc_op_t op, input sqc_cond_t c,
         input logic pin, input logic [6:0] m, input logic [5:0] r);
      @(posedge clk);
      instr <= {1'h1, op, c, pin, 1'h1, m, r, 16'h0000, 14'h0123, 10'h000};
      @(posedge clk);
      instr.valid <= 1'h0;
      #1;
   endtask

   task automatic endOfTest;
      if (miscompares == 0 && nChecks > 0)
      begin
         $display("No errors found");
      end
      else
      begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial
   begin
      repeat (3000) @(posedge clk);
      miscompares++;
      endOfTest();
   end

   initial
   begin
      rows = '{'{C_EQ, 8'h01, 1'h0, 1'h1}, '{C_NE, 8'h01, 1'h0, 1'h0},
         '{C_LT, 8'h02, 1'h0, 1'h1}, '{C_GE, 8'h06, 1'h0, 1'h1},
         '{C_LE, 8'h04, 1'h0, 1'h1}, '{C_GT, 8'h01, 1'h0, 1'h0},
         '{C_GT, 8'h00, 1'h0, 1'h1}, '{C_AC, 8'h08, 1'h0, 1'h1},
         '{C_NAC, 8'h08, 1'h0, 1'h0}, '{C_AV, 8'h04, 1'h0, 1'h1},
         '{C_NAV, 8'h00, 1'h0, 1'h1}, '{C_MV, 8'h40, 1'h0, 1'h1},
         '{C_NMV, 8'h40, 1'h0, 1'h0}, '{C_NEG, 8'h10, 1'h0, 1'h1},
         '{C_POS, 8'h10, 1'h0, 1'h0}, '{C_NCE, 8'h00, 1'h1, 1'h0},
         '{C_NCE, 8'h00, 1'h0, 1'h1}, '{C_TRUE, 8'h00, 1'h0, 1'h1}};
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      busRead(OFF_MODE);
      chk(v, {9'h000, MODE_RESET});
      foreach (rows[k])
      begin
         busWrite(OFF_FLAGS, {8'h00, rows[k].flags});
         ceExpired <= rows[k].ce;
         issue(OP_ARITH, rows[k].cond, 1'h0, 7'h00, 6'h00);
         chk(16'(execTaken), 16'(rows[k].exp));
      end
      flagInPin <= 1'h1;
      issue(OP_JUMP, C_TRUE, 1'h1, 7'h00, 6'h00);
      chk(16'(branchTaken), 16'h0001);
      issue(OP_ARITH, C_TRUE, 1'h1, 7'h00, 6'h00);
      chk(16'(execTaken), 16'h0000);
      flagInPin <= 1'h0;
      issue(OP_JUMP, C_TRUE, 1'h1, 7'h00, 6'h00);
      chk(16'(branchTaken), 16'h0000);
      issue(OP_JUMP, C_TRUE, 1'h0, 7'h00, 6'h00);
      chk(16'(branchTaken), 16'h0001);
      issue(OP_MODE_SET, C_TRUE, 1'h0, 7'h21, 6'h00);
      chk(16'(bankSel), 16'h0001);
      chk(16'(timerRun), 16'h0001);
      issue(OP_MODE_CLR, C_TRUE, 1'h0, 7'h20, 6'h00);
      chk(16'(timerRun), 16'h0000);
      busRead(OFF_MODE);
      chk(v, 16'h0001);
      busWrite(OFF_MODE, 16'h0012);
      dagAddr <= 14'h0001;
      repeat (2) @(posedge clk);
      #1 chk(16'(dagAddrOut), 16'h2000);
      chk(16'(fracMode), 16'h0001);
      busWrite(OFF_MODE, 16'h000C);
      arith <= {1'h1, 16'h8001, 1'h0, 1'h1, 1'h1, 1'h0, 4'h0};
      @(posedge clk);
      arith <= '0;
      issue(OP_TOS_WRITE, C_TRUE, 1'h0, 7'h00, ID_AR);
      busRead(OFF_PCTOP);
      chk(v, {2'b00, SAT_POS[13:0]});
      busRead(OFF_STATUS);
      chk(16'(v[4:1]), 16'h0001);
      @(posedge clk);
      arith <= {1'h1, 16'h0001, 1'h0, 1'h0, 1'h0, 1'h0, 4'h0};
      @(posedge clk);
      arith <= '0;
      busRead(OFF_FLAGS);
      chk(16'(v[FL_OVF]), 16'h0001);
      busWrite(OFF_FLAGS, 16'h0000);
      busRead(OFF_FLAGS);
      chk(16'(v[FL_OVF]), 16'h0000);
      issue(OP_TOS_READ, C_TRUE, 1'h0, 7'h00, 6'h00);
      issue(OP_NOP, C_TRUE, 1'h0, 7'h00, 6'h00);
      busRead(OFF_STATUS);
      chk(16'(v[4:1]), 16'h0000);
      issue(OP_TOS_WRITE, C_TRUE, 1'h0, 7'h00, 6'h00);
      busRead(OFF_PCTOP);
      chk(v, {2'b00, SAT_POS[13:0]});
      issue(OP_TOS_WRITE, C_TRUE, 1'h0, 7'h00, 6'h13);
      busRead(OFF_STATUS);
      chk(v & 16'h001F, 16'h0003);
      busWrite(OFF_MODE, 16'h0000);
      busGrant <= 1'h1;
      repeat (2) @(posedge clk);
      #1 chk(16'(stall), 16'h0001);
      busGrant <= 1'h0;
      busWrite(OFF_MODE, 16'h0040);
      busGrant <= 1'h1;
      repeat (2) @(posedge clk);
      #1 chk(16'(stall), 16'h0000);
      extAccess <= 1'h1;
      @(posedge clk);
      #1 chk(16'(stall), 16'h0001);
      busGrant <= 1'h0;
      extAccess <= 1'h0;
      ceExpired <= 1'h1;
      loopCond <= C_NCE;
      loopEnd <= 1'h1;
      @(posedge clk);
      loopEnd <= 1'h0;
      #1 chk(16'(loopContinue), 16'h0001);
      loopCond <= C_TRUE;
      loopEnd <= 1'h1;
      @(posedge clk);
      loopEnd <= 1'h0;
      #1 chk(16'(loopContinue), 16'h0000);
      // secondary bank result register is untouched by earlier saturation
      busWrite(OFF_MODE, 16'h0021);
      issue(OP_TOS_WRITE, C_TRUE, 1'h0, 7'h00, ID_AR);
      busRead(OFF_PCTOP);
      chk(v, 16'h0000);
      @(posedge clk);
      instr <= {1'h1, OP_INT_ENTRY, C_TRUE, 1'h0, 1'h1, 7'h00, 6'h00,
         16'h0000, 14'h0123, 10'h2A5};
      @(posedge clk);
      instr.valid <= 1'h0;
      busWrite(OFF_MODE, 16'h0000);
      issue(OP_NOP, C_TRUE, 1'h0, 7'h00, 6'h00);
      issue(OP_RTI, C_TRUE, 1'h0, 7'h00, 6'h00);
      chk(16'(imaskRestoreValid), 16'h0001);
      chk(16'(imaskRestore), 16'h02A5);
      busRead(OFF_MODE);
      chk(v, 16'h0021);
      // reset in mid-run returns the mode register to its reset value
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      #1 chk(16'(timerRun), 16'h0000);
      chk(16'(bankSel), 16'h0000);
      busRead(OFF_MODE);
      chk(v, {9'h000, MODE_RESET});
      endOfTest();
   end
endmodule

bind sqc_sequencer sqc_sequencer_monitor mon (.clk, .rst_n, .bus, .instr,
   .dagAddr, .dagAddrOut, .busGrant, .extAccess, .stall, .ceExpired,
   .loopEnd, .loopCond, .loopContinue, .execTaken, .branchTaken,
   .branchTarget, .bankSel, .fracMode, .timerRun);
